// *** src/dcsw_pkg.sv ***
// Package for the drive command and condition word block
package dcsw_pkg;
    localparam int CW = 16;
    // Command word bit positions
    localparam int CB_PRE_LO = 0;
    localparam int CB_PRE_HI = 1;
    localparam int CB_BRAKE = 2;
    localparam int CB_COAST = 3;
    localparam int CB_QSTOP = 4;
    localparam int CB_HOLD = 5;
    localparam int CB_START = 6;
    localparam int CB_RESET = 7;
    localparam int CB_JOG = 8;
    localparam int CB_RAMP = 9;
    localparam int CB_VALID = 10;
    localparam int CB_RLY1 = 11;
    localparam int CB_RLY2 = 12;
    localparam int CB_SET_LO = 13;
    localparam int CB_SET_HI = 14;
    localparam int CB_REV = 15;
    // Condition word bit positions
    localparam int SB_CTRL_RDY = 0;
    localparam int SB_DRV_RDY = 1;
    localparam int SB_ENABLE = 2;
    localparam int SB_TRIP = 3;
    localparam int SB_ERROR = 4;
    localparam int SB_UNUSED = 5;
    localparam int SB_TLOCK = 6;
    localparam int SB_WARN = 7;
    localparam int SB_ON_REF = 8;
    localparam int SB_BUS_CTL = 9;
    localparam int SB_FLIM_OK = 10;
    localparam int SB_IN_OP = 11;
    localparam int SB_AUTO_RS = 12;
    localparam int SB_VOLT = 13;
    localparam int SB_TORQ = 14;
    localparam int SB_TIMER = 15;
    // Reset values and scaling
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] REF_FULL = 16'h4000;
    // Source selection for bus/input combination
    typedef enum logic [1:0] {
        DCSW_SRC_INPUT = 2'h0,
        DCSW_SRC_BUS = 2'h1,
        DCSW_SRC_AND = 2'h2,
        DCSW_SRC_OR = 2'h3
    } dcsw_src_t;
endpackage : dcsw_pkg

// *** src/dcsw_core.sv ***
// Drive command word decoder and condition word composer
// Notes on behaviour
// R1 - Bit 02 low: DC brake then stop
// R2 - Bit 03 low: output stage off, coast
// R3 - Bit 04 low: quick-stop ramp to standstill
// R4 - Bit 05 low: freeze output frequency
// R5 - Frozen: stop only by coast/brake/inputs
// R6 - Bit 06 low: ramp stop; high permits start
// R7 - Bit 07 rising edge clears trip
// R8 - Bit 08 high: run at jog speed
// R9 - Bit 09 selects ramp set one or two
// R10 - Bit 10 low: whole word ignored
// R11 - Bits 11/12 drive relays if configured
// R12 - Bits 14:13 pick set-up in multi mode
// R13 - Bit 15 reverses if source allows
// R14 - Bus bits combine with inputs per source
// R15 - Status 00..02: ready, drive ready, enable
// R16 - Status 03,04,06,07: trip, error, lock, warn
// R17 - Status 08: speed equals reference
// R18 - Status 09: bus control accepted
// R19 - Status 10 limits ok, 11 in operation
// R20 - Status 12..15: temp, voltage, torque, timer
// R21 - Link lost forces status to zero
// R22 - References scaled 16384 equals 100 percent
// R23 - Bits 01:00 select one of four presets
// R24 - Status bit 05 always zero
`timescale 1ns/10ps
module dcsw_core
    import dcsw_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Command word from the fieldbus
    input wire logic cmd_word_stb,
    input wire logic [dcsw_pkg::CW-1:0] drive_command_word,
    input wire logic [15:0] bus_speed_ref,
    // Configuration
    input wire dcsw_pkg::dcsw_src_t preset_src,
    input wire dcsw_pkg::dcsw_src_t coast_src,
    input wire dcsw_pkg::dcsw_src_t start_src,
    input wire dcsw_pkg::dcsw_src_t setup_src,
    input wire dcsw_pkg::dcsw_src_t reverse_src,
    input wire logic relay1_follows_bus,
    input wire logic relay2_follows_bus,
    input wire logic multi_setup_mode,
    // Digital input functions, active high except din_coast_n, which is active low
    input wire logic [1:0] din_preset,
    input wire logic din_coast_n,
    input wire logic din_start,
    input wire logic [1:0] din_setup,
    input wire logic din_reverse,
    input wire logic din_stop_req,
    // Drive conditions
    input wire logic tripped,
    input wire logic trip_locked,
    input wire logic error_no_trip,
    input wire logic warning,
    input wire logic drive_ready,
    input wire logic speed_on_ref,
    input wire logic local_active,
    input wire logic freq_in_limits,
    input wire logic freq_nonzero,
    input wire logic overtemp_autostart,
    input wire logic dc_volt_bad,
    input wire logic torque_over,
    input wire logic thermal_over,
    input wire logic link_ok,
    input wire logic [15:0] actual_freq_pct,
    // Drive commands
    output logic dc_brake_q,
    output logic coast_q,
    output logic quick_stop_q,
    output logic hold_freq_q,
    output logic ramp_stop_q,
    output logic trip_reset_q,
    output logic jog_q,
    output logic ramp2_sel_q,
    output logic relay1_q,
    output logic relay2_q,
    output logic [1:0] setup_sel_q,
    output logic reverse_q,
    output logic [1:0] preset_sel_q,
    output logic [15:0] speed_ref_q,
    // Status back to the fieldbus
    output logic [15:0] drive_condition_word_q,
    output logic [15:0] actual_output_value_q
);
    import dcsw_pkg::*;

    logic [15:0] cmd_q;
    logic rst_bit_q;

    // Bit map below only fits 16-bit words
    if (CW != 16) begin : g_width_check
        $error("command word width must be 16");
    end

    // Terminals are asynchronous: three stages, taken once two and three agree,
    // so a level caught mid-change never reaches the decode
    localparam logic [7:0] DIN_IDLE = 8'h20;
    logic [7:0] din_raw;
    logic [7:0] din_q;
    logic [1:0] din_preset_s;
    logic din_coast_n_s;
    logic din_start_s;
    logic [1:0] din_setup_s;
    logic din_reverse_s;
    logic din_stop_s;
    assign din_raw = {din_preset, din_coast_n, din_start, din_setup, din_reverse,
        din_stop_req};
    for (genvar gi = 0; gi < $bits(din_raw); gi++) begin : g_din_sync
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic f_q;
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                s1_q <= DIN_IDLE[gi];
                s2_q <= DIN_IDLE[gi];
                s3_q <= DIN_IDLE[gi];
                f_q <= DIN_IDLE[gi];
            end else begin
                s1_q <= din_raw[gi];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    f_q <= s3_q;
                end
            end
        end
        assign din_q[gi] = f_q;
    end
    assign {din_preset_s, din_coast_n_s, din_start_s, din_setup_s, din_reverse_s,
        din_stop_s} = din_q;

    function automatic logic mix(dcsw_src_t s, logic b, logic d);
        case (s)
            DCSW_SRC_BUS: mix = b;
            DCSW_SRC_AND: mix = b & d;
            DCSW_SRC_OR: mix = b | d;
            default: mix = d;
        endcase
    endfunction : mix

    // Latch only valid words; invalid ones leave everything as it was
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cmd_q <= CMD_RESET;
            speed_ref_q <= 16'h0000;
        end else if (cmd_word_stb && drive_command_word[CB_VALID]) begin // [R10]
            cmd_q <= drive_command_word;
            speed_ref_q <= bus_speed_ref; // [R22]
        end
    end

    // Edge detect on held reset bit, so a steady level never re-clears
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rst_bit_q <= 1'b0;
            trip_reset_q <= 1'b0;
        end else begin
            rst_bit_q <= cmd_q[CB_RESET];
            trip_reset_q <= cmd_q[CB_RESET] & ~rst_bit_q; // [R7]
        end
    end

    logic coast_run;
    logic start_ok;
    assign coast_run = mix(coast_src, cmd_q[CB_COAST], din_coast_n_s); // [R14]
    assign start_ok = mix(start_src, cmd_q[CB_START], din_start_s); // [R14]

    // Stop commands; while frozen only coast and brake paths act
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dc_brake_q <= 1'b0;
            coast_q <= 1'b1;
            quick_stop_q <= 1'b0;
            hold_freq_q <= 1'b0;
            ramp_stop_q <= 1'b1;
        end else begin
            hold_freq_q <= ~cmd_q[CB_HOLD]; // [R4]
            dc_brake_q <= ~cmd_q[CB_BRAKE] | din_stop_s; // [R1] [R5]
            coast_q <= ~coast_run; // [R2]
            quick_stop_q <= ~cmd_q[CB_QSTOP] & cmd_q[CB_HOLD]; // [R3] [R5]
            ramp_stop_q <= ~start_ok & cmd_q[CB_HOLD]; // [R6] [R5]
        end
    end

    // Run options, relays, set-up, direction, preset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            jog_q <= 1'b0;
            ramp2_sel_q <= 1'b0;
            relay1_q <= 1'b0;
            relay2_q <= 1'b0;
            setup_sel_q <= 2'h0;
            reverse_q <= 1'b0;
            preset_sel_q <= 2'h0;
        end else begin
            jog_q <= cmd_q[CB_JOG]; // [R8]
            ramp2_sel_q <= cmd_q[CB_RAMP]; // [R9]
            relay1_q <= relay1_follows_bus & cmd_q[CB_RLY1]; // [R11]
            relay2_q <= relay2_follows_bus & cmd_q[CB_RLY2]; // [R11]
            if (multi_setup_mode) begin // [R12]
                setup_sel_q[0] <= mix(setup_src, cmd_q[CB_SET_LO], din_setup_s[0]); // [R14]
                setup_sel_q[1] <= mix(setup_src, cmd_q[CB_SET_HI], din_setup_s[1]); // [R14]
            end
            reverse_q <= mix(reverse_src, cmd_q[CB_REV], din_reverse_s); // [R13]
            preset_sel_q[0] <= mix(preset_src, cmd_q[CB_PRE_LO], din_preset_s[0]); // [R23]
            preset_sel_q[1] <= mix(preset_src, cmd_q[CB_PRE_HI], din_preset_s[1]); // [R23]
        end
    end

    // Condition word
    logic [15:0] cond_d;
    always_comb begin
        cond_d = 16'h0000;
        cond_d[SB_CTRL_RDY] = ~tripped; // [R15]
        cond_d[SB_DRV_RDY] = drive_ready; // [R15]
        cond_d[SB_ENABLE] = coast_run; // [R15]
        cond_d[SB_TRIP] = tripped; // [R16]
        cond_d[SB_ERROR] = error_no_trip; // [R16]
        cond_d[SB_UNUSED] = 1'b0; // [R24]
        cond_d[SB_TLOCK] = trip_locked; // [R16]
        cond_d[SB_WARN] = warning; // [R16]
        cond_d[SB_ON_REF] = speed_on_ref; // [R17]
        cond_d[SB_BUS_CTL] = ~local_active; // [R18]
        cond_d[SB_FLIM_OK] = freq_in_limits; // [R19]
        cond_d[SB_IN_OP] = start_ok | freq_nonzero; // [R19]
        cond_d[SB_AUTO_RS] = overtemp_autostart; // [R20]
        cond_d[SB_VOLT] = dc_volt_bad; // [R20]
        cond_d[SB_TORQ] = torque_over; // [R20]
        cond_d[SB_TIMER] = thermal_over; // [R20]
        if (!link_ok) begin
            cond_d = 16'h0000; // [R21]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            drive_condition_word_q <= 16'h0000;
            actual_output_value_q <= 16'h0000;
        end else begin
            drive_condition_word_q <= cond_d;
            actual_output_value_q <= actual_freq_pct; // [R22]
        end
    end

    // Checks
    chk_invalid_ignored: assert property (@(posedge mclk) disable iff (reset) // [R10]
        (cmd_word_stb && !drive_command_word[CB_VALID]) |=> $stable(cmd_q))
        else $error("invalid word changed command");
    chk_reset_edge: assert property (@(posedge mclk) disable iff (reset) // [R7]
        trip_reset_q |-> $past(cmd_q[CB_RESET]) && !$past(rst_bit_q))
        else $error("trip reset without rising edge");
    chk_reset_pulse: assert property (@(posedge mclk) disable iff (reset) // [R7]
        trip_reset_q |=> !trip_reset_q)
        else $error("trip reset longer than one cycle");
    chk_link_zero: assert property (@(posedge mclk) disable iff (reset) // [R21]
        !link_ok |=> drive_condition_word_q == 16'h0000)
        else $error("status not cleared on link loss");
    chk_bit5_zero: assert property (@(posedge mclk) disable iff (reset) // [R24]
        !drive_condition_word_q[SB_UNUSED])
        else $error("status bit 5 set");
    chk_brake_cmd: assert property (@(posedge mclk) disable iff (reset) // [R1]
        !cmd_q[CB_BRAKE] |=> dc_brake_q)
        else $error("brake not applied");
    chk_coast_cmd: assert property (@(posedge mclk) disable iff (reset) // [R2]
        (coast_src == DCSW_SRC_BUS && !cmd_q[CB_COAST]) |=> coast_q)
        else $error("coast not applied");
    chk_relay_gate: assert property (@(posedge mclk) disable iff (reset) // [R11]
        !relay1_follows_bus |=> !relay1_q)
        else $error("relay one driven while unassigned");
    chk_trip_bits: assert property (@(posedge mclk) disable iff (reset) // [R15]
        (link_ok && tripped) |=> drive_condition_word_q[SB_TRIP]
            && !drive_condition_word_q[SB_CTRL_RDY])
        else $error("trip bits wrong");
    chk_jog_cmd: assert property (@(posedge mclk) disable iff (reset) // [R8]
        cmd_q[CB_JOG] |=> jog_q)
        else $error("jog not followed");
    chk_hold_cmd: assert property (@(posedge mclk) disable iff (reset) // [R4]
        !cmd_q[CB_HOLD] |=> hold_freq_q)
        else $error("hold not applied");
    chk_qstop_cmd: assert property (@(posedge mclk) disable iff (reset) // [R3]
        (!cmd_q[CB_QSTOP] && cmd_q[CB_HOLD]) |=> quick_stop_q)
        else $error("quick stop not applied");
    chk_frozen_stops: assert property (@(posedge mclk) disable iff (reset) // [R5]
        !cmd_q[CB_HOLD] |=> !quick_stop_q && !ramp_stop_q)
        else $error("ramp stop acted while frozen");
    chk_stop_input: assert property (@(posedge mclk) disable iff (reset) // [R5]
        din_stop_s |=> dc_brake_q)
        else $error("stop input did not brake");
    chk_setup_hold: assert property (@(posedge mclk) disable iff (reset) // [R12]
        !multi_setup_mode |=> $stable(setup_sel_q))
        else $error("set-up changed outside multi mode");
    chk_reverse_input: assert property (@(posedge mclk) disable iff (reset) // [R13]
        (reverse_src == DCSW_SRC_INPUT) |=> reverse_q == $past(din_reverse_s))
        else $error("reverse not taken from input");
    chk_ref_latch: assert property (@(posedge mclk) disable iff (reset) // [R22]
        (cmd_word_stb && drive_command_word[CB_VALID]) |=> speed_ref_q == $past(bus_speed_ref))
        else $error("speed reference not taken");
    cov_valid_word: cover property (@(posedge mclk) disable iff (reset)
        cmd_word_stb && drive_command_word[CB_VALID]);
    cov_trip_reset: cover property (@(posedge mclk) disable iff (reset) trip_reset_q);
    cov_link_loss: cover property (@(posedge mclk) disable iff (reset) !link_ok);
    cov_frozen_stop: cover property (@(posedge mclk) disable iff (reset)
        !cmd_q[CB_HOLD] && din_stop_s);
endmodule : dcsw_core

// *** sim/dcsw_master.sv ***
// Fieldbus master model that sends command words to the drive
`timescale 1ns/10ps
module dcsw_master (
    // Clock
    input wire logic mclk,
    // Word and reference to the drive
    output logic cmd_word_stb,
    output logic [15:0] drive_command_word,
    output logic [15:0] bus_speed_ref
);
    initial begin
        cmd_word_stb = 1'b0;
        drive_command_word = 16'h0000;
        bus_speed_ref = 16'h0000;
    end
    // One word per cycle; calls in a row give back-to-back words
    // Bit 10 low is how a parameter-only message is sent
    // Reference is signed percent, 16'h4000 at full scale
    task automatic send(input logic [15:0] w, input logic [15:0] r);
        @(negedge mclk);
        cmd_word_stb = 1'b1;
        drive_command_word = w;
        bus_speed_ref = r;
    endtask : send
    // Released lines drop the strobe and show inverted data, so a stale word is never taken
    task automatic release_bus();
        @(negedge mclk);
        cmd_word_stb = 1'b0;
        drive_command_word = ~drive_command_word;
        bus_speed_ref = ~bus_speed_ref;
    endtask : release_bus
endmodule : dcsw_master

// *** sim/tb_top.sv ***
// Testbench for the drive command and condition word block
`timescale 1ns/10ps
module tb_top;
    import dcsw_pkg::*;
    logic mclk, reset, rf1, rf2, msm, stop_req, link, drev;
    dcsw_src_t bus_s, rev_s;
    logic [12:0] cond;
    logic [15:0] afreq, w_last;
    logic stb, dcb, cst, qst, hld, rst, trp, jog, rp2, ry1, ry2, rev;
    logic [1:0] sup, pre;
    logic [15:0] word, ref_in, sref, stat, aout;
    int num_errors = 0, n_tests = 0, pulses = 0, p0 = 0;
    logic [13:0] e;
    wire logic [13:0] cmd_out = {dcb, cst, qst, hld, rst, jog, rp2, ry1, ry2, sup, rev, pre};

    dcsw_master master (.mclk(mclk), .cmd_word_stb(stb), .drive_command_word(word),
        .bus_speed_ref(ref_in));
    dcsw_core DUT (.mclk(mclk), .reset(reset), .cmd_word_stb(stb),
        .drive_command_word(word), .bus_speed_ref(ref_in), .preset_src(bus_s),
        .coast_src(bus_s), .start_src(bus_s), .setup_src(bus_s), .reverse_src(rev_s),
        .relay1_follows_bus(rf1), .relay2_follows_bus(rf2), .multi_setup_mode(msm),
        .din_preset(2'h0), .din_coast_n(1'b1), .din_start(1'b0), .din_setup(2'h0),
        .din_reverse(drev), .din_stop_req(stop_req), .tripped(cond[0]),
        .trip_locked(cond[1]), .error_no_trip(cond[2]), .warning(cond[3]),
        .drive_ready(cond[4]), .speed_on_ref(cond[5]), .local_active(cond[6]),
        .freq_in_limits(cond[7]), .freq_nonzero(cond[8]), .overtemp_autostart(cond[9]),
        .dc_volt_bad(cond[10]), .torque_over(cond[11]), .thermal_over(cond[12]),
        .link_ok(link), .actual_freq_pct(afreq), .dc_brake_q(dcb), .coast_q(cst),
        .quick_stop_q(qst), .hold_freq_q(hld), .ramp_stop_q(rst), .trip_reset_q(trp),
        .jog_q(jog), .ramp2_sel_q(rp2), .relay1_q(ry1), .relay2_q(ry2), .setup_sel_q(sup),
        .reverse_q(rev), .preset_sel_q(pre), .speed_ref_q(sref),
        .drive_condition_word_q(stat), .actual_output_value_q(aout));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(negedge mclk) if (trp === 1'b1) pulses++;

    // Freeze masks quick stop and ramp stop, as chosen for this block
    function automatic logic [13:0] exp_cmd(input logic [15:0] w);
        return {~w[2], ~w[3], ~w[4] & w[5], ~w[5], ~w[6] & w[5], w[8], w[9], w[11], w[12],
            w[14:13], w[15], w[1:0]};
    endfunction : exp_cmd
    function automatic logic [15:0] exp_stat(input logic [12:0] c, input logic [15:0] w);
        return {c[12:9], w[6] | c[8], c[7], ~c[6], c[5], c[3], c[1], 1'b0, c[2], c[0],
            w[3], c[4], ~c[0]};
    endfunction : exp_stat
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic put(input logic [15:0] w, input logic [15:0] r);
        master.send(w, r);
        master.release_bus();
        repeat (3) @(negedge mclk);
    endtask : put
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        logic [15:0] tw [4] = '{16'hFD7B, 16'h4E62, 16'h8448, 16'h3C3C};
        logic [15:0] tr [4] = '{16'h4000, 16'hC000, 16'h2000, 16'h7FFF};
        logic [12:0] tc [3] = '{13'h1555, 13'h0AA8, 13'h1FFF};
        reset = 1'b1;
        {rf1, rf2, msm, link, stop_req} = 5'b11110;
        drev = 1'b0;
        bus_s = DCSW_SRC_BUS;
        rev_s = DCSW_SRC_BUS;
        cond = 13'h0000;
        afreq = 16'h0000;
        repeat (2) @(negedge mclk);
        check(16'(cmd_out), 16'h1200);
        reset = 1'b0;
        repeat (2) @(negedge mclk);
        check(16'(cmd_out), 16'(exp_cmd(16'h0000)));
        for (int i = 0; i < 4; i++) begin
            put(tw[i], tr[i]);
            check(16'(cmd_out), 16'(exp_cmd(tw[i])));
            check(sref, tr[i]);
        end
        // Back-to-back words: the last one wins
        master.send(16'h3C3C, 16'h1111);
        put(16'hFD7B, 16'hF000);
        check(16'(cmd_out), 16'(exp_cmd(16'hFD7B)));
        put(16'hFBFF, 16'h1234);
        check(16'(cmd_out), 16'(exp_cmd(16'hFD7B)));
        check(sref, 16'hF000);
        {rf1, rf2, msm} = 3'b000;
        rev_s = DCSW_SRC_INPUT;
        // Set-up keeps 11 from the last word taken in multi mode
        put(16'hDFFF, 16'h0000);
        e = exp_cmd(16'hDFFF);
        e[6:2] = {2'b00, 2'b11, 1'b0};
        check(16'(cmd_out), 16'(e));
        {rf1, rf2, msm} = 3'b111;
        rev_s = DCSW_SRC_OR;
        drev = 1'b1;
        stop_req = 1'b1;
        // Frozen word: only the stop input brakes; reverse comes in through OR
        put(16'h044C, 16'h0000);
        e = exp_cmd(16'h044C);
        e[13] = 1'b1;
        e[2] = 1'b1;
        check(16'(cmd_out), 16'(e));
        stop_req = 1'b0;
        p0 = pulses;
        master.send(16'h04FC, 16'h0000);
        master.release_bus();
        @(negedge mclk);
        check(16'(trp), 16'h0001);
        @(negedge mclk);
        check(16'(trp), 16'h0000);
        put(16'h04FC, 16'h0000);
        check(16'(pulses - p0), 16'h0001);
        w_last = 16'h04FC;
        for (int i = 0; i < 3; i++) begin
            cond = tc[i];
            afreq = tr[i];
            repeat (2) @(negedge mclk);
            check(stat, exp_stat(tc[i], w_last));
            check(aout, tr[i]);
        end
        link = 1'b0;
        repeat (2) @(negedge mclk);
        check(stat, 16'h0000);
        report_and_stop();
    end
endmodule : tb_top
